// *** common/rtc_ctl_pkg.sv ***
// Purpose: Shared constants for the clock control, flag and charger registers.
// Assumes: Byte-wide registers reached by address over a simple strobe port.
// Notes: Field positions, reset patterns and codes for the design and host live here; the checker and bench repeat some as literals.
package rtc_ctl_pkg;
	// ----------------------------------------------------------------
	// Register addresses and reset patterns.
	// ----------------------------------------------------------------
	localparam logic [7:0] OSC_OUTPUT_CONTROL_ADDR = 8'h0E;
	localparam logic [7:0] ALARM_OSC_FLAGS_ADDR = 8'h0F;
	localparam logic [7:0] BACKUP_CHARGE_SELECT_ADDR = 8'h10;
	localparam logic [7:0] OSC_OUTPUT_CONTROL_RST = 8'h18;
	localparam logic [7:0] ALARM_OSC_FLAGS_RST = 8'h80;
	localparam logic [7:0] BACKUP_CHARGE_SELECT_RST = 8'h00;
	// Mask of implemented bits; the rest read as zero.
	localparam logic [7:0] CONTROL_USED_MASK = 8'hBF;
	localparam logic [7:0] FLAGS_USED_MASK = 8'h83;
	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int OSC_DISABLE_BIT = 7;
	localparam int BACKUP_OUT_EN_BIT = 5;
	localparam int RATE_HIGH_BIT = 4;
	localparam int RATE_LOW_BIT = 3;
	localparam int IRQ_SELECT_BIT = 2;
	localparam int ALARM_TWO_IE_BIT = 1;
	localparam int ALARM_ONE_IE_BIT = 0;
	localparam int OSC_STOP_FLAG_BIT = 7;
	localparam int ALARM_TWO_FLAG_BIT = 1;
	localparam int ALARM_ONE_FLAG_BIT = 0;
	localparam int KEY_MSB = 7;
	localparam int KEY_LSB = 4;
	localparam int DIODE_MSB = 3;
	localparam int DIODE_LSB = 2;
	localparam int RES_MSB = 1;
	localparam int RES_LSB = 0;
	// ----------------------------------------------------------------
	// Charger codes and square-wave rates.
	// ----------------------------------------------------------------
	localparam logic [3:0] CHARGE_KEY = 4'hA;
	localparam logic [1:0] DIODE_NONE = 2'h1;
	localparam logic [1:0] DIODE_ONE = 2'h2;
	localparam logic [1:0] RES_OFF = 2'h0;
	localparam logic [1:0] RES_200_OHM = 2'h1;
	localparam logic [1:0] RATE_1HZ = 2'h0;
	localparam logic [1:0] RATE_4096HZ = 2'h1;
	localparam logic [1:0] RATE_8192HZ = 2'h2;
	// Divider of 32768 Hz edges; bit n toggles every 2^n edges.
	localparam int DIV_WIDTH = 15;
	localparam int DIV_BIT_1HZ = 14;
	localparam int DIV_BIT_4096HZ = 2;
	localparam int DIV_BIT_8192HZ = 1;
	typedef enum logic [1:0] {
		HOST_IDLE = 2'h0,
		HOST_ISSUE = 2'h1,
		HOST_WAIT = 2'h3
	} host_state_t;
endpackage

// *** common/rtc_reg_if.sv ***
// Purpose: Register port joining the clock device and its controlling master.
// Assumes: One clock shared by both ends.
// Notes: A strobe lasts one cycle; read data answers one cycle later.
`timescale 1ns/10ps
interface rtc_reg_if (
	input wire logic CLK // Shared clock.
);
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	modport device (input CLK, input reg_addr, input reg_wdata, input reg_wr, input reg_rd,
		output reg_rdata, output reg_rvalid);
	modport host (input CLK, output reg_addr, output reg_wdata, output reg_wr, output reg_rd,
		input reg_rdata, input reg_rvalid);
endinterface

// *** design/rtc_ctl_device.sv ***
// Purpose: Control, flag and charger registers of a serial real-time clock.
// Assumes: Oscillator, backup and stop sense arrive as pins; alarm matches are same-clock pulses.
// Notes: The output pin is open-drain, so only a low level is ever driven.
// Functional notes
// R1 - Disable bit high stops oscillator; resets low.
// R2 - On backup, pin works only if enabled.
// R3 - Rate bits pick 1Hz, 4096, 8192, 32768.
// R4 - Select bit picks alarm interrupt or wave.
// R5 - Control resets to pattern 0x18.
// R6 - Alarm two drives pin when enabled, interrupt mode.
// R7 - Alarm one drives pin when enabled, interrupt mode.
// R8 - Either enabled flag holds pin low.
// R9 - Stop flag set on run-to-stop edge.
// R10 - Stop flag set at reset and disable.
// R11 - Stop flag cleared only by writing zero.
// R12 - Alarm two flag set on match, write-zero clears.
// R13 - Alarm one flag set on match, write-zero clears.
// R14 - Charger needs key 1010.
// R15 - Diode codes 01 none, 10 one, else off.
// R16 - Resistor codes 01,10,11; 00 disables.
// R17 - Charger register resets to zero.
// R18 - Master avoids 200 ohm above 3.63V.
// R19 - Unused bits read zero, ignore writes.
// R20 - Alarm output stays until flag cleared.
// R21 - Pin driven low or released only.
`timescale 1ns/10ps
module rtc_ctl_device (
	input wire logic CLK, // System clock, 125 MHz.
	input wire logic RESETN, // Synchronous reset, active low.
	rtc_reg_if.device BUS, // Register port.
	input wire logic OSC_32K, // Oscillator output, asynchronous.
	input wire logic OSC_FAULT, // Oscillator fails to swing, asynchronous.
	input wire logic ON_BACKUP_SUPPLY, // Part runs from the backup supply, asynchronous.
	input wire logic ALARM_ONE_MATCH, // One-cycle pulse from alarm one compare.
	input wire logic ALARM_TWO_MATCH, // One-cycle pulse from alarm two compare.
	output logic OSC_RUN, // Oscillator enable to the analog cell.
	output logic WAVE_IRQ_PIN_O, // Output value of the open-drain pin, always low.
	output logic WAVE_IRQ_PIN_OE, // High while the pin is pulled low.
	output logic CHARGE_EN, // Charger connected.
	output logic CHARGE_DIODE, // One series diode in the charge path.
	output logic [1:0] CHARGE_RES // Resistor bits of the charger register, any code 00 to 11.
);
	// ----------------------------------------------------------------
	// Pin synchronisers.
	// ----------------------------------------------------------------
	logic [1:0] osc_sync_r;
	logic [1:0] fault_sync_r;
	logic [1:0] backup_sync_r;
	logic osc_prev_r;

	// Two stages keep metastability away from the divider and flag logic.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			osc_sync_r <= 2'h0;
			fault_sync_r <= 2'h0;
			backup_sync_r <= 2'h0;
			osc_prev_r <= 1'b0;
		end else begin
			osc_sync_r <= {osc_sync_r[0], OSC_32K};
			fault_sync_r <= {fault_sync_r[0], OSC_FAULT};
			backup_sync_r <= {backup_sync_r[0], ON_BACKUP_SUPPLY};
			osc_prev_r <= osc_sync_r[1];
		end
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	logic [7:0] control_r;
	logic [7:0] flags_r;
	logic [7:0] charge_r;
	logic [7:0] flags_nxt;
	logic running;
	logic running_r;
	logic wr_control;
	logic wr_flags;
	logic wr_charge;

	assign wr_control = BUS.reg_wr && (BUS.reg_addr == rtc_ctl_pkg::OSC_OUTPUT_CONTROL_ADDR);
	assign wr_flags = BUS.reg_wr && (BUS.reg_addr == rtc_ctl_pkg::ALARM_OSC_FLAGS_ADDR);
	assign wr_charge = BUS.reg_wr && (BUS.reg_addr == rtc_ctl_pkg::BACKUP_CHARGE_SELECT_ADDR);
	// The oscillator runs only while enabled and not sensed as failed.
	assign running = !control_r[rtc_ctl_pkg::OSC_DISABLE_BIT] && !fault_sync_r[1]; // R1

	// Control register; the unused bit is masked so it never stores.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			control_r <= rtc_ctl_pkg::OSC_OUTPUT_CONTROL_RST; // R5
		end else if (wr_control) begin
			control_r <= BUS.reg_wdata & rtc_ctl_pkg::CONTROL_USED_MASK; // R19
		end
	end

	// Charger register resets to all zero, leaving the charger off.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			charge_r <= rtc_ctl_pkg::BACKUP_CHARGE_SELECT_RST; // R17
		end else if (wr_charge) begin
			charge_r <= BUS.reg_wdata;
		end
	end

	// Flags: a write can only clear, and a set in the same cycle wins.
	always_comb begin
		flags_nxt = flags_r;
		if (wr_flags) begin
			flags_nxt = flags_r & BUS.reg_wdata; // R11 R12 R13
		end
		if (running_r && !running) begin
			flags_nxt[rtc_ctl_pkg::OSC_STOP_FLAG_BIT] = 1'b1; // R9 R10
		end
		if (ALARM_TWO_MATCH) begin
			flags_nxt[rtc_ctl_pkg::ALARM_TWO_FLAG_BIT] = 1'b1; // R12
		end
		if (ALARM_ONE_MATCH) begin
			flags_nxt[rtc_ctl_pkg::ALARM_ONE_FLAG_BIT] = 1'b1; // R13
		end
		flags_nxt = flags_nxt & rtc_ctl_pkg::FLAGS_USED_MASK; // R19
	end

	// The stop flag comes up set, since time is not trusted after reset.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			flags_r <= rtc_ctl_pkg::ALARM_OSC_FLAGS_RST; // R10
			running_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			running_r <= running;
		end
	end

	// Read answer one cycle after the strobe; unknown addresses read zero.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			BUS.reg_rdata <= 8'h00;
			BUS.reg_rvalid <= 1'b0;
		end else begin
			BUS.reg_rvalid <= BUS.reg_rd;
			if (BUS.reg_rd) begin
				case (BUS.reg_addr)
					rtc_ctl_pkg::OSC_OUTPUT_CONTROL_ADDR: BUS.reg_rdata <= control_r;
					rtc_ctl_pkg::ALARM_OSC_FLAGS_ADDR: BUS.reg_rdata <= flags_r;
					rtc_ctl_pkg::BACKUP_CHARGE_SELECT_ADDR: BUS.reg_rdata <= charge_r;
					default: BUS.reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Square-wave divider.
	// ----------------------------------------------------------------
	logic [rtc_ctl_pkg::DIV_WIDTH-1:0] div_r;
	logic wave;

	// Counts oscillator rising edges; a stopped oscillator freezes it.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			div_r <= '0;
		end else if (running && osc_sync_r[1] && !osc_prev_r) begin
			div_r <= div_r + 1'b1;
		end
	end

	// Rate selection from the two rate bits.
	always_comb begin
		case (control_r[rtc_ctl_pkg::RATE_HIGH_BIT:rtc_ctl_pkg::RATE_LOW_BIT])
			rtc_ctl_pkg::RATE_1HZ: wave = div_r[rtc_ctl_pkg::DIV_BIT_1HZ]; // R3
			rtc_ctl_pkg::RATE_4096HZ: wave = div_r[rtc_ctl_pkg::DIV_BIT_4096HZ]; // R3
			rtc_ctl_pkg::RATE_8192HZ: wave = div_r[rtc_ctl_pkg::DIV_BIT_8192HZ]; // R3
			default: wave = osc_prev_r && running; // R3
		endcase
	end

	// ----------------------------------------------------------------
	// Output pin and charger decode.
	// ----------------------------------------------------------------
	logic irq_active;
	logic pin_low;
	logic pin_allowed;
	logic [3:0] key;
	logic [1:0] diode;
	logic [1:0] res;

	// Interrupt stays asserted while any enabled flag remains set.
	assign irq_active = (flags_r[rtc_ctl_pkg::ALARM_TWO_FLAG_BIT] && control_r[rtc_ctl_pkg::ALARM_TWO_IE_BIT]) // R6
		|| (flags_r[rtc_ctl_pkg::ALARM_ONE_FLAG_BIT] && control_r[rtc_ctl_pkg::ALARM_ONE_IE_BIT]); // R7 R8 R20
	assign pin_allowed = !backup_sync_r[1] || control_r[rtc_ctl_pkg::BACKUP_OUT_EN_BIT]; // R2
	assign pin_low = control_r[rtc_ctl_pkg::IRQ_SELECT_BIT] ? irq_active : !wave; // R4
	assign key = charge_r[rtc_ctl_pkg::KEY_MSB:rtc_ctl_pkg::KEY_LSB];
	assign diode = charge_r[rtc_ctl_pkg::DIODE_MSB:rtc_ctl_pkg::DIODE_LSB];
	assign res = charge_r[rtc_ctl_pkg::RES_MSB:rtc_ctl_pkg::RES_LSB];

	// All outputs are flopped; the pin value is a constant low.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			OSC_RUN <= 1'b0;
			WAVE_IRQ_PIN_O <= 1'b0;
			WAVE_IRQ_PIN_OE <= 1'b0;
		end else begin
			OSC_RUN <= running; // R1
			WAVE_IRQ_PIN_O <= 1'b0; // R21
			WAVE_IRQ_PIN_OE <= pin_low && pin_allowed; // R2 R21
		end
	end

	// The key guards against a stray write turning the charger on.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			CHARGE_EN <= 1'b0;
			CHARGE_DIODE <= 1'b0;
			CHARGE_RES <= 2'h0;
		end else begin
			CHARGE_EN <= (key == rtc_ctl_pkg::CHARGE_KEY) // R14
				&& (diode == rtc_ctl_pkg::DIODE_NONE || diode == rtc_ctl_pkg::DIODE_ONE) // R15
				&& (res != rtc_ctl_pkg::RES_OFF); // R16
			CHARGE_DIODE <= (diode == rtc_ctl_pkg::DIODE_ONE); // R15
			CHARGE_RES <= res; // R16
		end
	end
endmodule

// *** design/rtc_ctl_host.sv ***
// Purpose: Master end that issues register reads and writes to the clock device.
// Assumes: Commands from same-clock logic; supply level sense arrives as a pin.
// Notes: One command is in flight at a time.
`timescale 1ns/10ps
module rtc_ctl_host (
	input wire logic CLK, // System clock, 125 MHz.
	input wire logic RESETN, // Synchronous reset, active low.
	rtc_reg_if.host BUS, // Register port.
	input wire logic SUPPLY_ABOVE_LIMIT, // Main supply above 3.63V, asynchronous.
	input wire logic CMD_VALID, // Command offered.
	input wire logic CMD_WRITE, // High for write, low for read.
	input wire logic [7:0] CMD_ADDR, // Register address.
	input wire logic [7:0] CMD_WDATA, // Write data.
	output logic CMD_READY, // Host can take a command.
	output logic RSP_VALID, // One-cycle pulse with read data.
	output logic [7:0] RSP_DATA // Read data.
);
	// ----------------------------------------------------------------
	// Supply sense and command sequencer.
	// ----------------------------------------------------------------
	logic [1:0] supply_sync_r;
	rtc_ctl_pkg::host_state_t state_r;
	logic [7:0] wdata;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			supply_sync_r <= 2'h0;
		end else begin
			supply_sync_r <= {supply_sync_r[0], SUPPLY_ABOVE_LIMIT};
		end
	end

	// A 200 ohm request on a high supply is turned into a resistor-off code.
	always_comb begin
		wdata = CMD_WDATA;
		if (CMD_ADDR == rtc_ctl_pkg::BACKUP_CHARGE_SELECT_ADDR && supply_sync_r[1]
			&& CMD_WDATA[rtc_ctl_pkg::RES_MSB:rtc_ctl_pkg::RES_LSB] == rtc_ctl_pkg::RES_200_OHM) begin
			wdata[rtc_ctl_pkg::RES_MSB:rtc_ctl_pkg::RES_LSB] = rtc_ctl_pkg::RES_OFF; // R18
		end
	end

	// Strobes last one cycle; reads wait for the device answer.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_r <= rtc_ctl_pkg::HOST_IDLE;
			BUS.reg_addr <= 8'h00;
			BUS.reg_wdata <= 8'h00;
			BUS.reg_wr <= 1'b0;
			BUS.reg_rd <= 1'b0;
			CMD_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA <= 8'h00;
		end else begin
			BUS.reg_wr <= 1'b0;
			BUS.reg_rd <= 1'b0;
			RSP_VALID <= 1'b0;
			case (state_r)
				rtc_ctl_pkg::HOST_IDLE: begin
					CMD_READY <= 1'b1;
					if (CMD_VALID && CMD_READY) begin
						CMD_READY <= 1'b0;
						BUS.reg_addr <= CMD_ADDR;
						BUS.reg_wdata <= wdata; // R11 R12 R13
						BUS.reg_wr <= CMD_WRITE;
						BUS.reg_rd <= !CMD_WRITE;
						state_r <= CMD_WRITE ? rtc_ctl_pkg::HOST_IDLE : rtc_ctl_pkg::HOST_WAIT;
					end
				end
				rtc_ctl_pkg::HOST_WAIT: begin
					if (BUS.reg_rvalid) begin
						RSP_VALID <= 1'b1;
						RSP_DATA <= BUS.reg_rdata;
						CMD_READY <= 1'b1;
						state_r <= rtc_ctl_pkg::HOST_IDLE;
					end
				end
				default: begin
					state_r <= rtc_ctl_pkg::HOST_IDLE;
				end
			endcase
		end
	end
endmodule

// *** sim/rtc_ctl_chk.sv ***
// Purpose: Assertions on the register port and the device outputs.
// Assumes: One clock, synchronous active-low reset.
// Notes: Shadows of two registers are rebuilt from bus writes.
`timescale 1ns/10ps
module rtc_ctl_chk (
	input wire logic CLK, // Clock.
	input wire logic RESETN, // Reset, active low.
	input wire logic [7:0] reg_addr, // Address.
	input wire logic [7:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	input wire logic [7:0] reg_rdata, // Read data.
	input wire logic reg_rvalid, // Read answer.
	input wire logic WAVE_IRQ_PIN_O, // Pin value.
	input wire logic WAVE_IRQ_PIN_OE, // Pin pulled low.
	input wire logic CHARGE_EN, // Charger on.
	input wire logic [1:0] CHARGE_RES // Resistor code.
);
	// ----------------
	// Shadows
	// ----------------
	logic [7:0] ctrl_r;
	logic [7:0] chg_r;
	logic [1:0] age_r;
	logic chg_ok;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	// The age count lets output checks wait out the device pipeline.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ctrl_r <= 8'h18;
			chg_r <= 8'h00;
			age_r <= 2'h0;
		end else if (reg_wr && (reg_addr == 8'h0E || reg_addr == 8'h10)) begin
			ctrl_r <= (reg_addr == 8'h0E) ? reg_wdata : ctrl_r;
			chg_r <= (reg_addr == 8'h10) ? reg_wdata : chg_r;
			age_r <= 2'h0;
		end else if (age_r != 2'h3) begin
			age_r <= age_r + 2'h1;
		end
	end
	// Charger is on only for the key with a legal diode and resistor.
	assign chg_ok = chg_r[7:4] == 4'hA && (chg_r[3:2] == 2'h1 || chg_r[3:2] == 2'h2) && chg_r[1:0] != 2'h0;
	// ----------------
	// Assertions
	// ----------------
	a_read_answered: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	a_answer_from_read: assert property (reg_rvalid |-> $past(reg_rd) ##1 !reg_rvalid) else $error("stray answer");
	a_ctrl_gap_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h0E |-> !reg_rdata[6])
		else $error("control bit 6 set");
	a_flags_gap_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h0F |-> reg_rdata[6:2] == 5'h00)
		else $error("flag gap bits set");
	a_unmapped_zero: assert property (reg_rvalid && !($past(reg_addr) inside {8'h0E, 8'h0F, 8'h10})
		|-> reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_pin_low_only: assert property (WAVE_IRQ_PIN_OE |-> WAVE_IRQ_PIN_O == 1'b0) else $error("pin driven high");
	a_charge_gated: assert property (age_r == 2'h3 |-> CHARGE_EN == chg_ok && CHARGE_RES == chg_r[1:0])
		else $error("charger outputs wrong");
	a_irq_masked: assert property (age_r == 2'h3 && ctrl_r[2] && ctrl_r[1:0] == 2'h0 |-> !WAVE_IRQ_PIN_OE)
		else $error("masked alarm drives pin");
	c_read: cover property (reg_rvalid);
	c_pin_low: cover property (WAVE_IRQ_PIN_OE && ctrl_r[2]);
	c_charge: cover property (CHARGE_EN);
endmodule

// *** sim/rtc_control_status_trickle_test.sv ***
// Purpose: Self-checking bench driving the host command port.
// Assumes: Host and device face each other on one interface.
// Notes: The oscillator input is sped up so rates show in a short run.
`timescale 1ns/10ps
module rtc_control_status_trickle_test;
	logic clk, resetn, osc, osc_fault, on_backup, supply_high, cmd_valid, cmd_write;
	logic [1:0] match;
	logic [7:0] cmd_addr, cmd_wdata, rsp_data, d;
	logic cmd_ready, rsp_valid, osc_run, pin_o, pin_oe, chg_en, chg_diode;
	logic [1:0] chg_res;
	wire pin_level;
	int n_errors, check_count;
	int tog[5];
	logic [7:0] codes[10] = '{8'hA5, 8'hA9, 8'hA6, 8'hAA, 8'hA7, 8'hAB, 8'h55, 8'hA1, 8'hAD, 8'hA4};
	logic [7:0] modes[5] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h1C};
	// ----------------
	// Structure
	// ----------------
	// Pull-up gives the open-drain wire its high level.
	assign pin_level = pin_oe ? pin_o : 1'b1;
	rtc_reg_if bus_if (.CLK(clk));
	rtc_ctl_device rtc_ctl_device_inst (.CLK(clk), .RESETN(resetn), .BUS(bus_if), .OSC_32K(osc),
		.OSC_FAULT(osc_fault), .ON_BACKUP_SUPPLY(on_backup), .ALARM_ONE_MATCH(match[0]),
		.ALARM_TWO_MATCH(match[1]), .OSC_RUN(osc_run),
		.WAVE_IRQ_PIN_O(pin_o), .WAVE_IRQ_PIN_OE(pin_oe), .CHARGE_EN(chg_en), .CHARGE_DIODE(chg_diode),
		.CHARGE_RES(chg_res));
	rtc_ctl_host rtc_ctl_host_inst (.CLK(clk), .RESETN(resetn), .BUS(bus_if), .SUPPLY_ABOVE_LIMIT(supply_high),
		.CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
	rtc_ctl_chk rtc_ctl_chk_inst (.CLK(clk), .RESETN(resetn), .reg_addr(bus_if.reg_addr),
		.reg_wdata(bus_if.reg_wdata), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd), .reg_rdata(bus_if.reg_rdata),
		.reg_rvalid(bus_if.reg_rvalid), .WAVE_IRQ_PIN_O(pin_o), .WAVE_IRQ_PIN_OE(pin_oe), .CHARGE_EN(chg_en),
		.CHARGE_RES(chg_res));
	// Clock of 8 ns and a fast stand-in oscillator that changes on falling clock edges.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		osc = 1'b0;
		forever #40 osc = ~osc;
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Signals are read right after the edge, so they still hold what that edge sampled.
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
		int i;
		i = 0;
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr <= addr;
		cmd_wdata <= wdata;
		do begin
			@(posedge clk);
			i++;
		end while (cmd_ready !== 1'b1 && i < 20);
		cmd_valid <= 1'b0;
		while (!wr && rsp_valid !== 1'b1 && i < 20) begin
			@(posedge clk);
			i++;
		end
		d = rsp_data;
		if (i >= 20) begin
			chk(1'b0, "command port stuck");
			print_verdict();
		end
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		xfer(1'b0, addr, 8'h00);
		chk(d === exp, $sformatf("read %h gave %h, want %h", addr, d, exp));
	endtask
	task automatic wait_pin(input logic exp);
		int i;
		for (i = 0; i < 40 && pin_level !== exp; i++) begin
			@(posedge clk);
		end
		chk(pin_level === exp, "pin level wrong");
		if (pin_level !== exp) begin
			print_verdict();
		end
	endtask
	task automatic pulse(input int idx);
		match[idx] <= 1'b1;
		@(posedge clk);
		match <= 2'h0;
		@(posedge clk);
	endtask
	// ----------------
	// Sequence
	// ----------------
	initial begin
		{resetn, osc_fault, on_backup, supply_high, cmd_valid, cmd_write, match} = '0;
		{cmd_addr, cmd_wdata} = '0;
		n_errors = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd_chk(8'h0E, 8'h18);
		rd_chk(8'h0F, 8'h80);
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h11, 8'h00);
		chk(osc_run === 1'b1, "oscillator idle");
		xfer(1'b1, 8'h0F, 8'hFF);
		rd_chk(8'h0F, 8'h80);
		xfer(1'b1, 8'h0F, 8'h7F);
		rd_chk(8'h0F, 8'h00);
		xfer(1'b1, 8'h0E, 8'hFF);
		rd_chk(8'h0E, 8'hBF);
		rd_chk(8'h0F, 8'h80);
		chk(osc_run === 1'b0, "oscillator still on");
		// A stopped oscillator must not set the flag again once cleared.
		xfer(1'b1, 8'h0F, 8'h00);
		rd_chk(8'h0F, 8'h00);
		xfer(1'b1, 8'h0E, 8'h07);
		pulse(0);
		rd_chk(8'h0F, 8'h01);
		wait_pin(1'b0);
		pulse(1);
		rd_chk(8'h0F, 8'h03);
		xfer(1'b1, 8'h0F, 8'hFE);
		rd_chk(8'h0F, 8'h02);
		wait_pin(1'b0);
		xfer(1'b1, 8'h0F, 8'h00);
		wait_pin(1'b1);
		xfer(1'b1, 8'h0E, 8'h05);
		pulse(1);
		rd_chk(8'h0F, 8'h02);
		chk(pin_level === 1'b1, "masked alarm on pin");
		xfer(1'b1, 8'h0E, 8'h06);
		wait_pin(1'b0);
		on_backup <= 1'b1;
		wait_pin(1'b1);
		xfer(1'b1, 8'h0E, 8'h26);
		wait_pin(1'b0);
		on_backup <= 1'b0;
		xfer(1'b1, 8'h0F, 8'h00);
		// Count pin transitions for each rate and for interrupt mode.
		for (int m = 0; m < 5; m++) begin
			xfer(1'b1, 8'h0E, modes[m]);
			// The pin moves once on the mode change itself, so let it settle before counting.
			repeat (4) @(posedge clk);
			tog[m] = 0;
			for (int c = 0; c < 200; c++) begin
				d[0] = pin_level;
				@(posedge clk);
				tog[m] += (d[0] !== pin_level) ? 1 : 0;
			end
		end
		chk(tog[0] == 0 && tog[1] > 0 && tog[2] > tog[1] && tog[3] > tog[2], "rate order wrong");
		chk(tog[4] == 0, "wave in interrupt mode");
		for (int k = 0; k < 10; k++) begin
			xfer(1'b1, 8'h10, codes[k]);
			rd_chk(8'h10, codes[k]);
			chk(chg_en === 1'(k < 6) && chg_res === codes[k][1:0], "charger enable or resistor");
			chk(k >= 6 || chg_diode === codes[k][3], "charger diode");
		end
		supply_high <= 1'b1;
		// The supply sense passes two flip-flops in the host before it can act.
		repeat (3) @(posedge clk);
		xfer(1'b1, 8'h10, 8'hA5);
		rd_chk(8'h10, 8'hA4);
		chk(chg_en === 1'b0, "charger on at high supply");
		supply_high <= 1'b0;
		// A failing oscillator must stop the run output and raise the stop flag.
		osc_fault <= 1'b1;
		repeat (4) @(posedge clk);
		rd_chk(8'h0F, 8'h80);
		chk(osc_run === 1'b0, "oscillator runs while failed");
		osc_fault <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(1'b1, 8'h0F, 8'h00);
		rd_chk(8'h0F, 8'h00);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h0E, 8'h18);
		rd_chk(8'h0F, 8'h80);
		print_verdict();
	end
endmodule
